// ---- lock_key_watchdog_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lock_key_watchdog_regs.svh"
module lock_key_watchdog_timer #(
   parameter int unsigned TICK_CYCLES = `WDG_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Special-function register port
   input wire wdog_pkg::byte_t sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire wdog_pkg::byte_t sfr_wdata,
   output var wdog_pkg::byte_t sfr_rdata,
   // Oscillator control
   input wire logic slow_osc_off_req,
   output var logic slow_osc_run,
   // Chip reset request
   output var logic chip_reset_req
);
   import wdog_pkg::*;

   tick_if tk_bus ();

   slow_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clock(clock),
      .resetn(resetn),
      .tk(tk_bus)
   );

   // Limit minus one in units of divided ticks
   function automatic count_t limit_m1(input interval_t sel);
      logic [16:0] lim;
      lim = 17'h1 << {sel, 1'b0};
      lim = lim << `WDG_LIMIT_BASE_SHIFT;
      return count_t'(lim - 17'h1);
   endfunction

   logic tick;
   logic wr;
   logic rd;
   logic apply_en;
   logic apply_dis;
   logic over;

   logic enabled_q, enabled_d;
   logic lock_q, lock_d;
   interval_t ivl_q, ivl_d;
   count_t count_q, count_d;
   logic [2:0] win_q, win_d;
   delay_t pend_en_q, pend_en_d;
   delay_t pend_dis_q, pend_dis_d;
   byte_t rdata_q, rdata_d;
   logic osc_q, osc_d;
   logic rst_q, rst_d;

   assign tick = tk_bus.tick;
   assign wr = sfr_wr && (sfr_addr == `WDG_CMD_ADDR);
   assign rd = sfr_rd && (sfr_addr == `WDG_CMD_ADDR);
   assign apply_en = tick && (pend_en_q == 2'h1);
   assign apply_dis = tick && (pend_dis_q == 2'h1);
   // Above-limit compare not gated by enable; equal-limit compare needs enable and tick
   assign over = (count_q > limit_m1(ivl_q)) ||
                 ((count_q == limit_m1(ivl_q)) && enabled_q && tick && !apply_en);

   always_comb begin
      enabled_d = enabled_q;
      lock_d = lock_q;
      ivl_d = ivl_q;
      count_d = count_q;
      win_d = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
      pend_en_d = pend_en_q;
      pend_dis_d = pend_dis_q;
      if (tick && pend_en_q != 2'h0) begin
         pend_en_d = pend_en_q - 2'h1;
      end
      if (tick && pend_dis_q != 2'h0) begin
         pend_dis_d = pend_dis_q - 2'h1;
      end
      if (wr) begin
         win_d = 3'h0;
         if (!sfr_wdata[`WDG_CMD_BIT]) begin
            ivl_d = sfr_wdata[`WDG_IVL_HI:`WDG_IVL_LO];
         end else if (sfr_wdata == `WDG_CMD_RESTART) begin
            pend_en_d = `WDG_EN_DELAY;
         end else if (sfr_wdata == `WDG_CMD_DIS_KEY1) begin
            win_d = `WDG_KEY_WINDOW;
         end else if (sfr_wdata == `WDG_CMD_DIS_KEY2) begin
            if (win_q != 3'h0 && !lock_q) begin
               pend_dis_d = `WDG_DIS_DELAY;
            end
         end else if (sfr_wdata == `WDG_CMD_LOCK) begin
            lock_d = 1'b1;
         end
      end
      if (enabled_q && tick) begin
         count_d = count_q + 16'h1;
      end
      if (apply_dis) begin
         enabled_d = 1'b0;
      end
      if (apply_en) begin
         enabled_d = 1'b1;
         count_d = `WDG_COUNT_RESET;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         enabled_q <= 1'b1;
         lock_q <= 1'b0;
         ivl_q <= `WDG_IVL_RESET;
         count_q <= `WDG_COUNT_RESET;
         win_q <= 3'h0;
         pend_en_q <= 2'h0;
         pend_dis_q <= 2'h0;
      end else begin
         enabled_q <= enabled_d;
         lock_q <= lock_d;
         ivl_q <= ivl_d;
         count_q <= count_d;
         win_q <= win_d;
         pend_en_q <= pend_en_d;
         pend_dis_q <= pend_dis_d;
      end
   end

   // Outputs and read data
   always_comb begin
      rdata_d = 8'h00;
      if (rd) begin
         rdata_d[`WDG_IVL_HI:`WDG_IVL_LO] = ivl_q;
         rdata_d[`WDG_STAT_BIT] = enabled_q;
      end
      osc_d = enabled_q || !slow_osc_off_req;
      rst_d = rst_q || over;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
         osc_q <= 1'b1;
         rst_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         osc_q <= osc_d;
         rst_q <= rst_d;
      end
   end

   assign sfr_rdata = rdata_q;
   assign slow_osc_run = osc_q;
   assign chip_reset_req = rst_q;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   chk_restart_arms: assert property (
      wr && sfr_wdata == `WDG_CMD_RESTART |=> pend_en_q == `WDG_EN_DELAY)
      else $error("restart not scheduled");
   chk_restart_applies: assert property (
      apply_en |=> enabled_q && count_q == 16'h0000)
      else $error("restart did not clear and enable");
   chk_count_step: assert property (
      enabled_q && tick && !apply_en && !apply_dis |=> count_q == $past(count_q) + 16'h1)
      else $error("counter did not advance on tick");
   chk_freeze_count: assert property (
      !enabled_q && !apply_en |=> count_q == $past(count_q))
      else $error("disabled counter moved");
   chk_key_pair: assert property (
      wr && sfr_wdata == `WDG_CMD_DIS_KEY1 && !lock_q ##[1:4]
      (wr && sfr_wdata == `WDG_CMD_DIS_KEY2 && $past(!wr) && !lock_q)
      |=> pend_dis_q == `WDG_DIS_DELAY)
      else $error("timed disable sequence not accepted");
   chk_key_late: assert property (
      wr && sfr_wdata == `WDG_CMD_DIS_KEY2 && win_q == 3'h0 && pend_dis_q == 2'h0
      |=> pend_dis_q == 2'h0)
      else $error("late disable key accepted");
   chk_lock_blocks: assert property (
      lock_q && pend_dis_q == 2'h0 |=> pend_dis_q == 2'h0)
      else $error("disable armed while locked");
   chk_lock_sticky: assert property (lock_q |=> lock_q)
      else $error("lock released without reset");
   chk_interval_load: assert property (
      wr && !sfr_wdata[`WDG_CMD_BIT] |=> ivl_q == $past(sfr_wdata[2:0]))
      else $error("interval not loaded");
   chk_overflow_reset: assert property (
      count_q > limit_m1(ivl_q) |=> chip_reset_req)
      else $error("overflow did not raise reset");
   chk_osc_forced: assert property (enabled_q |=> slow_osc_run)
      else $error("oscillator stopped while active");
   chk_status_read: assert property (
      rd |=> sfr_rdata == {3'h0, $past(enabled_q), 1'b0, $past(ivl_q)})
      else $error("status read wrong");

   cov_restart: cover property (apply_en);
   cov_disable: cover property (apply_dis ##1 !enabled_q);
   cov_lock: cover property (wr && sfr_wdata == `WDG_CMD_LOCK);
   cov_reset: cover property ($rose(chip_reset_req));
endmodule
`default_nettype wire

// ---- lock_key_watchdog_regs.svh ----
`ifndef LOCK_KEY_WATCHDOG_REGS_SVH
`define LOCK_KEY_WATCHDOG_REGS_SVH

// Register address on the special-function bus
`define WDG_CMD_ADDR 8'h97

// Command bytes
`define WDG_CMD_RESTART 8'ha5
`define WDG_CMD_DIS_KEY1 8'hde
`define WDG_CMD_DIS_KEY2 8'had
`define WDG_CMD_LOCK 8'hff

// Field positions
`define WDG_CMD_BIT 7
`define WDG_STAT_BIT 4
`define WDG_IVL_HI 2
`define WDG_IVL_LO 0

// Reset values
`define WDG_IVL_RESET 3'h7
`define WDG_COUNT_RESET 16'h0000

// Timing
`define WDG_CLK_PERIOD_NS 10
`define WDG_LFO_PERIOD_NS 12500
`define WDG_LFO_PRESCALE 16
`define WDG_TICK_CYCLES ((`WDG_LFO_PERIOD_NS * `WDG_LFO_PRESCALE) / `WDG_CLK_PERIOD_NS)
`define WDG_KEY_WINDOW 3'h4
`define WDG_EN_DELAY 2'h2
`define WDG_DIS_DELAY 2'h3
`define WDG_LIMIT_BASE_SHIFT 2

`endif

// ---- wdt_pkg.sv ----
`default_nettype none
package wdog_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] interval_t;
   typedef logic [15:0] count_t;
   typedef logic [1:0] delay_t;
endpackage
`default_nettype wire

// ---- tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface
`default_nettype wire

// ---- slow_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lock_key_watchdog_regs.svh"
module slow_tick_gen #(
   parameter int unsigned TICK_CYCLES = `WDG_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Divided slow_oscillator tick
   tick_if.src tk
);
   import wdog_pkg::*;

   logic [31:0] div_q;
   logic [31:0] div_d;
   logic tick_q;
   logic tick_d;

   // Divider of the slow_oscillator down to the counter tick
   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + 32'h1;
      if (div_q >= 32'(TICK_CYCLES - 1)) begin
         div_d = 32'h0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_q <= 32'h0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tk.tick = tick_q;

   chk_tick_single_pulse: assert property (@(posedge clock) disable iff (!resetn)
      tick_q |=> !tick_q) else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// ---- lock_key_watchdog_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lock_key_watchdog_regs.svh"
module lock_key_watchdog_timer_tb;
   import wdog_pkg::*;
   localparam int unsigned TICKS = 8;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   byte_t sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   byte_t sfr_wdata = 8'h00;
   byte_t sfr_rdata;
   logic slow_osc_off_req = 1'b0;
   logic slow_osc_run;
   logic chip_reset_req;
   int fail_count = 0;
   int checks = 0;

   lock_key_watchdog_timer #(.TICK_CYCLES(TICKS)) i_lock_key_watchdog_timer (
      .clock(clock),
      .resetn(resetn),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .slow_osc_off_req(slow_osc_off_req),
      .slow_osc_run(slow_osc_run),
      .chip_reset_req(chip_reset_req)
   );

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check8(input string what, input byte_t exp, input byte_t got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic reset_dut();
      resetn = 1'b0;
      cycles(16);
      resetn = 1'b1;
   endtask

   // One write strobe, next request gap cycles later; one command per call
   task automatic wr(input byte_t a, input byte_t d, input int gap);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clock);
      sfr_wr = 1'b0;
      cycles(gap - 1);
   endtask

   task automatic rd(input string what, input byte_t a, input byte_t exp);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clock);
      sfr_rd = 1'b0;
      check8(what, exp, sfr_rdata);
   endtask

   task automatic wait_reset(input int n);
      for (int i = 0; i < n && chip_reset_req !== 1'b1; i++) @(negedge clock);
      check8("chip reset", 8'h01, {7'h00, chip_reset_req});
      if (chip_reset_req !== 1'b1) final_report();
   endtask

   task automatic t_reset_values();
      rd("status after reset", `WDG_CMD_ADDR, 8'h17);
      check8("osc run", 8'h01, {7'h00, slow_osc_run});
      check8("no reset", 8'h00, {7'h00, chip_reset_req});
      rd("unmapped read", 8'h98, 8'h00);
      wr(8'h98, 8'h00, 10);
      rd("after unmapped write", `WDG_CMD_ADDR, 8'h17);
   endtask

   task automatic t_interval();
      wr(`WDG_CMD_ADDR, 8'h03, 10);
      rd("interval 3", `WDG_CMD_ADDR, 8'h13);
      wr(`WDG_CMD_ADDR, 8'h81, 10);
      rd("unknown command", `WDG_CMD_ADDR, 8'h13);
      wr(`WDG_CMD_ADDR, 8'h07, 10);
      rd("interval 7", `WDG_CMD_ADDR, 8'h17);
   endtask

   task automatic t_disable();
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY1, 5);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY2, 10);
      cycles(40);
      rd("late key ignored", `WDG_CMD_ADDR, 8'h17);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY1, 4);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY2, 10);
      cycles(40);
      rd("disabled", `WDG_CMD_ADDR, 8'h07);
      slow_osc_off_req = 1'b1;
      cycles(3);
      check8("osc stopped", 8'h00, {7'h00, slow_osc_run});
      wr(`WDG_CMD_ADDR, `WDG_CMD_RESTART, 30);
      rd("re-enabled", `WDG_CMD_ADDR, 8'h17);
      check8("osc forced", 8'h01, {7'h00, slow_osc_run});
      slow_osc_off_req = 1'b0;
   endtask

   // Frozen count above the new limit trips reset while disabled
   // Skips the restart before shortening on purpose, the hazard avoids
   task automatic t_freeze();
      reset_dut();
      cycles(80);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY1, 1);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY2, 50);
      rd("disabled", `WDG_CMD_ADDR, 8'h07);
      check8("no reset yet", 8'h00, {7'h00, chip_reset_req});
      wr(`WDG_CMD_ADDR, 8'h00, 1);
      wait_reset(10);
   endtask

   // Interval 0 limit is 4 ticks
   task automatic t_overflow();
      reset_dut();
      wr(`WDG_CMD_ADDR, 8'h00, 1);
      cycles(23);
      check8("before limit", 8'h00, {7'h00, chip_reset_req});
      wait_reset(20);
   endtask

   // Interval 1 limit is 16 ticks; restart pushes overflow out
   task automatic t_restart();
      reset_dut();
      wr(`WDG_CMD_ADDR, 8'h01, 1);
      cycles(88);
      wr(`WDG_CMD_ADDR, `WDG_CMD_RESTART, 1);
      cycles(110);
      check8("restart cleared", 8'h00, {7'h00, chip_reset_req});
      wait_reset(60);
   endtask

   task automatic t_lock();
      reset_dut();
      wr(`WDG_CMD_ADDR, `WDG_CMD_LOCK, 10);
      rd("lock keeps state", `WDG_CMD_ADDR, 8'h17);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY1, 1);
      wr(`WDG_CMD_ADDR, `WDG_CMD_DIS_KEY2, 40);
      rd("locked", `WDG_CMD_ADDR, 8'h17);
   endtask

   initial begin
      reset_dut();
      t_reset_values();
      t_interval();
      t_disable();
      t_freeze();
      t_overflow();
      t_restart();
      t_lock();
      final_report();
   end
endmodule
`default_nettype wire
